// *** hw/i2t_overload_limiter_regs.svh ***
`ifndef I2T_OVERLOAD_LIMITER_REGS_SVH
`define I2T_OVERLOAD_LIMITER_REGS_SVH

// Register byte offsets
`define I2T_OFS_CTRL          8'h00
`define I2T_OFS_MAX_BOUND     8'h04
`define I2T_OFS_RATED         8'h08
`define I2T_OFS_PEAK_SETTING  8'h0c
`define I2T_OFS_PEAK_DURATION 8'h10
`define I2T_OFS_BUDGET_LO     8'h14
`define I2T_OFS_BUDGET_HI     8'h18
`define I2T_OFS_ACCUM_LO      8'h1c
`define I2T_OFS_ACCUM_HI      8'h20
`define I2T_OFS_LIMIT         8'h24
`define I2T_OFS_STATUS        8'h28
`define I2T_OFS_CLAMP_COUNT   8'h2c

// Field positions
`define I2T_CTRL_CLOSED_LOOP_BIT 0
`define I2T_CTRL_CLEAR_BIT       1
`define I2T_STAT_ACTIVE_BIT      0
`define I2T_STAT_CLAMPED_BIT     1

// Reset values
`define I2T_RST_CLOSED_LOOP   1'b0
`define I2T_RST_MAX_BOUND     16'hffff
`define I2T_RST_RATED         16'h0000
`define I2T_RST_PEAK_SETTING  16'h03e8
`define I2T_RST_PEAK_DURATION 16'h0000

// Peak setting is in tenths of a percent
`define I2T_PERMILLE_DIV      32'h0000_03e8
// Duration is in ms, accumulation is in us
`define I2T_US_PER_MS         32'h0000_03e8
// Control period of the current loop, in us
`define I2T_CONTROL_PERIOD_US 32'h0000_03e8

`endif

// *** hw/i2t_pkg.sv ***
package i2t_pkg;

    typedef struct packed {
        logic        closed_loop;
        logic [15:0] max_bound_ma;
        logic [15:0] rated_ma;
        logic [15:0] peak_setting;
        logic [15:0] peak_duration_ms;
        logic        wr_pending;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hready;
        logic [63:0] accumulated_heat_value;
        logic        clamped;
        logic [15:0] imposed_current_limit;
        logic        active;
        logic [31:0] clamp_count;
    } state_type;

    typedef struct packed {
        logic [15:0] peak_ma;
        logic        peak_above_rated;
        logic [31:0] rated_sq;
        logic [63:0] thermal_budget_limit;
    } calc_state_type;

endpackage

// *** hw/i2t_cfg_if.sv ***
`timescale 1ns/10ps

interface i2t_cfg_if;
    logic [15:0] rated_ma;
    logic [15:0] peak_setting;
    logic [15:0] max_bound_ma;
    logic [15:0] peak_duration_ms;
    logic [15:0] peak_ma;
    logic        peak_above_rated;
    logic [31:0] rated_sq;
    logic [63:0] thermal_budget_limit;

    modport limiter (
        output rated_ma,
        output peak_setting,
        output max_bound_ma,
        output peak_duration_ms,
        input  peak_ma,
        input  peak_above_rated,
        input  rated_sq,
        input  thermal_budget_limit
    );

    modport calc (
        input  rated_ma,
        input  peak_setting,
        input  max_bound_ma,
        input  peak_duration_ms,
        output peak_ma,
        output peak_above_rated,
        output rated_sq,
        output thermal_budget_limit
    );
endinterface

// *** hw/i2t_budget_calc.sv ***
`timescale 1ns/10ps
`include "i2t_overload_limiter_regs.svh"

module i2t_budget_calc (
    input  wire logic clk,
    input  wire logic reset,
    i2t_cfg_if.calc   cfg
);
    i2t_pkg::calc_state_type s;
    i2t_pkg::calc_state_type n;

    always_comb begin
        logic [31:0] peak_raw;
        logic [31:0] peak_sq;
        logic [31:0] excess_sq;
        logic [63:0] dur_us;
        peak_raw  = 32'h0000_0000;
        peak_sq   = 32'h0000_0000;
        excess_sq = 32'h0000_0000;
        dur_us    = 64'h0000_0000_0000_0000;
        n = s;
        peak_raw = (32'(cfg.rated_ma) * 32'(cfg.peak_setting)) / `I2T_PERMILLE_DIV;
        if (peak_raw > 32'(cfg.max_bound_ma)) begin
            n.peak_ma = cfg.max_bound_ma;
        end else begin
            n.peak_ma = peak_raw[15:0];
        end
        n.peak_above_rated = n.peak_ma > cfg.rated_ma;
        n.rated_sq = 32'(cfg.rated_ma) * 32'(cfg.rated_ma);
        peak_sq = 32'(n.peak_ma) * 32'(n.peak_ma);
        excess_sq = n.peak_above_rated ? (peak_sq - n.rated_sq) : 32'h0000_0000;
        dur_us = 64'(cfg.peak_duration_ms) * 64'(`I2T_US_PER_MS);
        // Budget in mA^2 * us: excess heating at peak held for the full duration
        n.thermal_budget_limit = 64'(excess_sq) * dur_us;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign cfg.peak_ma              = s.peak_ma;
    assign cfg.peak_above_rated     = s.peak_above_rated;
    assign cfg.rated_sq             = s.rated_sq;
    assign cfg.thermal_budget_limit = s.thermal_budget_limit;
endmodule

// *** hw/i2t_overload_limiter.sv ***
// Notes on behaviour
// - Limiting works only while the closed-loop bit (bit 0 of the submode control) is one.
// - An absolute motor current bound in mA is a writable configuration register.
// - The motor rated current in mA is a writable configuration register.
// - Peak current equals rated current times the peak setting divided by one thousand.
// - The permitted peak duration in ms is a writable configuration register.
// - The thermal budget limit is readable by software.
// - The accumulated heat value is readable and compared against the budget limit.
// - The current limit presently imposed is readable by software.
// - A status bit reads one while limiting is active and zero otherwise.
// - Limiting stays inactive if peak does not exceed rated or the duration is zero.
// - The budget limit is derived from rated current, peak current and duration.
// - Peak is allowed until the heat value reaches the budget, then rated at once.
// - The peak current is clamped to the absolute motor current bound.
// - Accumulation follows the real current history, so unspent heat shortens a new peak.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "i2t_overload_limiter_regs.svh"

module i2t_overload_limiter #(
    parameter logic [31:0] CONTROL_PERIOD_US = `I2T_CONTROL_PERIOD_US
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sample_valid,
    input  wire logic [15:0] measured_current_ma,
    output logic      [15:0] current_limit_ma,
    output logic             limiter_active,
    output logic             limiter_clamped
);
    localparam i2t_pkg::state_type STATE_RESET = '{
        closed_loop:            `I2T_RST_CLOSED_LOOP,
        max_bound_ma:           `I2T_RST_MAX_BOUND,
        rated_ma:               `I2T_RST_RATED,
        peak_setting:           `I2T_RST_PEAK_SETTING,
        peak_duration_ms:       `I2T_RST_PEAK_DURATION,
        wr_pending:             1'b0,
        wr_addr:                8'h00,
        hrdata:                 32'h0000_0000,
        hready:                 1'b1,
        accumulated_heat_value: 64'h0000_0000_0000_0000,
        clamped:                1'b0,
        imposed_current_limit:  `I2T_RST_MAX_BOUND,
        active:                 1'b0,
        clamp_count:            32'h0000_0000
    };

    i2t_pkg::state_type s;
    i2t_pkg::state_type n;

    i2t_cfg_if cfg ();

    i2t_budget_calc u_calc (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfg.calc)
    );

    assign cfg.rated_ma         = s.rated_ma;
    assign cfg.peak_setting     = s.peak_setting;
    assign cfg.max_bound_ma     = s.max_bound_ma;
    assign cfg.peak_duration_ms = s.peak_duration_ms;

    function automatic logic [31:0] read_word(
        input logic [7:0]         addr,
        input i2t_pkg::state_type st,
        input logic [63:0]        budget
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (addr)
            `I2T_OFS_CTRL: begin
                d[`I2T_CTRL_CLOSED_LOOP_BIT] = st.closed_loop;
            end
            `I2T_OFS_MAX_BOUND: begin
                d = 32'(st.max_bound_ma);
            end
            `I2T_OFS_RATED: begin
                d = 32'(st.rated_ma);
            end
            `I2T_OFS_PEAK_SETTING: begin
                d = 32'(st.peak_setting);
            end
            `I2T_OFS_PEAK_DURATION: begin
                d = 32'(st.peak_duration_ms);
            end
            `I2T_OFS_BUDGET_LO: begin
                d = budget[31:0];
            end
            `I2T_OFS_BUDGET_HI: begin
                d = budget[63:32];
            end
            `I2T_OFS_ACCUM_LO: begin
                d = st.accumulated_heat_value[31:0];
            end
            `I2T_OFS_ACCUM_HI: begin
                d = st.accumulated_heat_value[63:32];
            end
            `I2T_OFS_LIMIT: begin
                d = 32'(st.imposed_current_limit);
            end
            `I2T_OFS_STATUS: begin
                d[`I2T_STAT_ACTIVE_BIT]  = st.active;
                d[`I2T_STAT_CLAMPED_BIT] = st.clamped;
            end
            `I2T_OFS_CLAMP_COUNT: begin
                d = st.clamp_count;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    // Floors at zero instead of wrapping when the motor cools
    function automatic logic [63:0] heat_step(
        input logic [63:0] acc,
        input logic [31:0] meas_sq,
        input logic [31:0] rated_sq,
        input logic [31:0] period_us
    );
        logic [63:0] delta;
        logic [64:0] sum;
        delta = 64'h0000_0000_0000_0000;
        sum   = 65'h0_0000_0000_0000_0000;
        if (meas_sq >= rated_sq) begin
            delta = 64'(meas_sq - rated_sq) * 64'(period_us);
            sum = 65'(acc) + 65'(delta);
            // Saturate high rather than wrap back to a cold motor
            return sum[64] ? 64'hffff_ffff_ffff_ffff : sum[63:0];
        end else begin
            delta = 64'(rated_sq - meas_sq) * 64'(period_us);
            return (acc > delta) ? (acc - delta) : 64'h0000_0000_0000_0000;
        end
    endfunction

    // Read-only and unmapped offsets drop the write
    function automatic i2t_pkg::state_type apply_write(
        input i2t_pkg::state_type st,
        input logic [7:0]         addr,
        input logic [31:0]        data
    );
        i2t_pkg::state_type r;
        r = st;
        unique case (addr)
            `I2T_OFS_CTRL: begin
                r.closed_loop = data[`I2T_CTRL_CLOSED_LOOP_BIT];
            end
            `I2T_OFS_MAX_BOUND: begin
                r.max_bound_ma = data[15:0];
            end
            `I2T_OFS_RATED: begin
                r.rated_ma = data[15:0];
            end
            `I2T_OFS_PEAK_SETTING: begin
                r.peak_setting = data[15:0];
            end
            `I2T_OFS_PEAK_DURATION: begin
                r.peak_duration_ms = data[15:0];
            end
            default: begin
            end
        endcase
        return r;
    endfunction

    function automatic logic addr_taken(
        input logic       sel,
        input logic [1:0] trans,
        input logic       ready
    );
        return sel && trans[1] && ready;
    endfunction

    function automatic logic [31:0] square_ma(
        input logic [15:0] ma
    );
        return 32'(ma) * 32'(ma);
    endfunction

    // Zero budget means zero duration; both come from the same stage, never stale
    function automatic logic limiting_allowed(
        input logic        closed_loop,
        input logic        peak_above_rated,
        input logic [63:0] budget
    );
        return closed_loop && peak_above_rated
               && (budget != 64'h0000_0000_0000_0000);
    endfunction

    // Same comparison both ways: clamp at the budget, release below it
    function automatic logic at_budget(
        input logic [63:0] heat,
        input logic [63:0] budget
    );
        return heat >= budget;
    endfunction

    function automatic logic [15:0] pick_limit(
        input logic        clamp,
        input logic [15:0] rated_ma,
        input logic [15:0] peak_ma
    );
        return clamp ? rated_ma : peak_ma;
    endfunction

    // Counts engagements only, not cycles spent clamped
    function automatic logic [31:0] engaged_count(
        input logic [31:0] count,
        input logic        clamp_now,
        input logic        clamp_was
    );
        return (clamp_now && !clamp_was) ? count + 32'h0000_0001 : count;
    endfunction

    // Forget stored heat so a later enable starts from a cold motor
    function automatic i2t_pkg::state_type cool_down(
        input i2t_pkg::state_type st,
        input logic [15:0]        bound_ma
    );
        i2t_pkg::state_type r;
        r = st;
        r.accumulated_heat_value = 64'h0000_0000_0000_0000;
        r.clamped                = 1'b0;
        r.imposed_current_limit  = bound_ma;
        return r;
    endfunction

    always_comb begin
        logic        config_ok;
        logic [31:0] meas_sq;
        logic        clamp_now;
        config_ok = 1'b0;
        meas_sq   = 32'h0000_0000;
        clamp_now = 1'b0;
        n = s;
        // Zero wait states: the slave never holds the bus
        n.hready = 1'b1;

        // Data phase of a write taken last cycle
        if (s.wr_pending) begin
            n = apply_write(n, s.wr_addr, hwdata);
        end

        // Address phase; read data sees a write landing in this same cycle
        n.wr_pending = 1'b0;
        if (addr_taken(hsel, htrans, hready)) begin
            n.wr_pending = hwrite;
            n.wr_addr    = haddr[7:0];
            if (!hwrite) begin
                n.hrdata = read_word(haddr[7:0], n, cfg.thermal_budget_limit);
            end
        end

        // The peak flag and budget take one cycle through the budget calculator; the closed-loop bit does not
        config_ok = limiting_allowed(s.closed_loop, cfg.peak_above_rated,
                                     cfg.thermal_budget_limit);
        n.active = config_ok;

        if (!config_ok) begin
            n = cool_down(n, s.max_bound_ma);
        end else begin
            if (sample_valid) begin
                meas_sq = square_ma(measured_current_ma);
                n.accumulated_heat_value = heat_step(s.accumulated_heat_value, meas_sq,
                                                     cfg.rated_sq, CONTROL_PERIOD_US);
            end
            clamp_now = at_budget(n.accumulated_heat_value, cfg.thermal_budget_limit);
            n.clamped = clamp_now;
            n.clamp_count = engaged_count(s.clamp_count, clamp_now, s.clamped);
            n.imposed_current_limit = pick_limit(clamp_now, s.rated_ma, cfg.peak_ma);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= STATE_RESET;
        end else begin
            s <= n;
        end
    end

    assign hrdata           = s.hrdata;
    assign hreadyout        = s.hready;
    assign hresp            = 1'b0;
    assign current_limit_ma = s.imposed_current_limit;
    assign limiter_active   = s.active;
    assign limiter_clamped  = s.clamped;
endmodule

// *** verif/i2t_overload_limiter_assertions.sv ***
`timescale 1ns/10ps

module i2t_overload_limiter_assertions (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sample_valid,
    input wire logic [15:0] current_limit_ma,
    input wire logic        limiter_active,
    input wire logic        limiter_clamped
);
    logic [2:0] quiet_reg;
    logic [2:0] quiet_next;
    logic       quiet;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_addr_taken;
        hsel && htrans[1] && hready;
    endsequence

    sequence s_after_sample;
        $past(sample_valid);
    endsequence

    // A config write ripples for three edges; judge only settled stretches
    always_comb begin
        quiet_next = (quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1;
        if (hsel && htrans[1] && hready && hwrite)
            quiet_next = 3'h0;
    end

    always_ff @(posedge clk) begin
        if (reset)
            quiet_reg <= 3'h0;
        else
            quiet_reg <= quiet_next;
    end

    assign quiet = quiet_reg >= 3'h5;

    a_reset_values: assert property (
        $past(reset) |-> !limiter_active && !limiter_clamped && current_limit_ma == 16'hffff)
        else $error("outputs not at reset values");
    a_zero_wait: assert property (
        s_addr_taken |=> hreadyout && !hresp ##1 hreadyout)
        else $error("bus answer stalled or not okay");
    a_clamp_needs_active: assert property (
        limiter_clamped |-> limiter_active)
        else $error("clamped while inactive");
    a_active_settled: assert property (
        quiet |-> $stable(limiter_active))
        else $error("activity changed without a config write");
    a_hold_between: assert property (
        quiet && !$past(sample_valid) |-> $stable(current_limit_ma) && $stable(limiter_clamped))
        else $error("limit moved without a sample");
    a_clamp_on_sample: assert property (
        quiet && $rose(limiter_clamped) |->
            s_after_sample ##0 current_limit_ma < $past(current_limit_ma))
        else $error("clamp did not lower the limit on a sample");
    a_release_raise: assert property (
        quiet && $fell(limiter_clamped) |->
            s_after_sample ##0 current_limit_ma > $past(current_limit_ma))
        else $error("release did not restore peak on a sample");
    a_clamp_pinned: assert property (
        quiet && limiter_clamped && $past(limiter_clamped) |-> $stable(current_limit_ma))
        else $error("clamped limit drifted");
    a_no_cold_clamp: assert property (
        $rose(limiter_active) && !$past(sample_valid) |-> !limiter_clamped)
        else $error("clamped on enable without a sample");
endmodule

// *** verif/current_loop_model.sv ***
`timescale 1ns/10ps

module current_loop_model #(
    parameter int GAP = 4
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        run,
    input  wire logic [15:0] demand_ma,
    input  wire logic [15:0] current_limit_ma,
    output logic             sample_valid,
    output logic      [15:0] measured_current_ma,
    output int               n_samples
);
    int phase;

    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= 0;
            sample_valid <= 1'b0;
            measured_current_ma <= 16'h0000;
            n_samples <= 0;
        end else begin
            phase <= (phase == GAP - 1) ? 0 : phase + 1;
            sample_valid <= run && phase == 0;
            if (run && phase == 0) begin
                // The loop never drives past the imposed limit
                measured_current_ma <= (demand_ma < current_limit_ma) ? demand_ma : current_limit_ma;
                n_samples <= n_samples + 1;
            end else begin
                // Reading is stale between samples, so keep it moving
                measured_current_ma <= ~measured_current_ma;
            end
        end
    end
endmodule

// *** verif/i2t_overload_limiter_tb.sv ***
`timescale 1ns/10ps
`include "i2t_overload_limiter_regs.svh"

module i2t_overload_limiter_tb;
    logic        clk;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sample_valid;
    logic [15:0] measured_current_ma;
    logic [15:0] current_limit_ma;
    logic        limiter_active;
    logic        limiter_clamped;
    logic        run;
    logic [15:0] demand_ma;
    logic [31:0] rd;
    int          n_samples;
    int          n0;
    int          n_mismatch;
    int          checks;
    int          cycles;
    logic [15:0] mx_t [6] = '{16'h03e8, 16'hffff, 16'hffff, 16'hffff, 16'h04b0, 16'hffff};
    logic [15:0] st_t [6] = '{16'h05dc, 16'h03e8, 16'h05dc, 16'h05dc, 16'h05dc, 16'h05dc};
    logic [15:0] du_t [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0001};
    logic        ct_t [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [15:0] lim_t [6] = '{16'h03e8, 16'hffff, 16'hffff, 16'hffff, 16'h04b0, 16'h05dc};

    i2t_overload_limiter #(.CONTROL_PERIOD_US(32'h0000_0064)) dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sample_valid(sample_valid), .measured_current_ma(measured_current_ma),
        .current_limit_ma(current_limit_ma), .limiter_active(limiter_active),
        .limiter_clamped(limiter_clamped));

    current_loop_model #(.GAP(4)) loop_model (
        .clk(clk), .reset(reset), .run(run), .demand_ma(demand_ma),
        .current_limit_ma(current_limit_ma), .sample_valid(sample_valid),
        .measured_current_ma(measured_current_ma), .n_samples(n_samples));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask

    task chk_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask

    task cfg(input int i);
        bus(1'b1, `I2T_OFS_MAX_BOUND, {16'h0000, mx_t[i]});
        bus(1'b1, `I2T_OFS_RATED, 32'h0000_03e8);
        bus(1'b1, `I2T_OFS_PEAK_SETTING, {16'h0000, st_t[i]});
        bus(1'b1, `I2T_OFS_PEAK_DURATION, {16'h0000, du_t[i]});
        bus(1'b1, `I2T_OFS_CTRL, {31'h0, ct_t[i]});
        repeat (3) @(posedge clk);
    endtask

    // Run the loop until the clamp flag reaches the wanted level
    task spin(input logic [15:0] dm, input logic lvl);
        demand_ma <= dm;
        run <= 1'b1;
        n0 = n_samples;
        @(posedge clk);
        while (limiter_clamped !== lvl) @(posedge clk);
        run <= 1'b0;
    endtask

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        run = 1'b0;
        demand_ma = 16'h0000;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("limit pin", 32'h0000_ffff, {16'h0000, current_limit_ma});
        chk_reg("ctrl", `I2T_OFS_CTRL, 32'h0000_0000);
        chk_reg("max", `I2T_OFS_MAX_BOUND, 32'h0000_ffff);
        chk_reg("rated", `I2T_OFS_RATED, 32'h0000_0000);
        chk_reg("peak", `I2T_OFS_PEAK_SETTING, 32'h0000_03e8);
        chk_reg("dur", `I2T_OFS_PEAK_DURATION, 32'h0000_0000);
        chk_reg("status", `I2T_OFS_STATUS, 32'h0000_0000);
        chk_reg("unmapped", 8'h30, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            cfg(i);
            chk("active", {31'h0, i >= 4}, {31'h0, limiter_active});
            chk_reg("status", `I2T_OFS_STATUS, {31'h0, i >= 4});
            chk("limit", {16'h0000, lim_t[i]}, {16'h0000, current_limit_ma});
            if (i == 4)
                chk_reg("budget", `I2T_OFS_BUDGET_LO, 32'h1a39_de00);
            if (i == 5)
                chk_reg("budget", `I2T_OFS_BUDGET_LO, 32'h4a81_7c80);
        end
        chk_reg("budget hi", `I2T_OFS_BUDGET_HI, 32'h0000_0000);
        $display("test config done");
        spin(16'h05dc, 1'b1);
        chk("samples to clamp", 32'h0000_000a, 32'(n_samples - n0));
        chk("clamped limit", 32'h0000_03e8, {16'h0000, current_limit_ma});
        chk_reg("heat", `I2T_OFS_ACCUM_LO, 32'h4a81_7c80);
        spin(16'h01f4, 1'b0);
        chk("samples to release", 32'h0000_0001, 32'(n_samples - n0));
        spin(16'h05dc, 1'b1);
        chk("samples to reclamp", 32'h0000_0001, 32'(n_samples - n0));
        chk_reg("heat", `I2T_OFS_ACCUM_LO, 32'h4d7c_6d00);
        chk_reg("clamp count", `I2T_OFS_CLAMP_COUNT, 32'h0000_0002);
        bus(1'b1, `I2T_OFS_LIMIT, 32'h0000_0000);
        chk_reg("limit reg", `I2T_OFS_LIMIT, 32'h0000_03e8);
        $display("test clamp done");
        demand_ma <= 16'h0000;
        run <= 1'b1;
        n0 = n_samples;
        while (n_samples < n0 + 16) @(posedge clk);
        run <= 1'b0;
        chk_reg("heat lo", `I2T_OFS_ACCUM_LO, 32'h0000_0000);
        chk_reg("heat hi", `I2T_OFS_ACCUM_HI, 32'h0000_0000);
        chk("released limit", 32'h0000_05dc, {16'h0000, current_limit_ma});
        $display("test floor done");
        close_out();
    end
endmodule

bind i2t_overload_limiter i2t_overload_limiter_assertions chk_u (
    .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
    .current_limit_ma(current_limit_ma), .limiter_active(limiter_active),
    .limiter_clamped(limiter_clamped));
